// file: burst2_sram_ports.sv
// Two-port burst-of-two SRAM: input capture, array, read pipeline, echo, DLL, impedance
// Notes on behaviour
// - Two arrays of 512K x 18; each access moves two words at consecutive addresses.
// - Port selects and byte selects are captured on input clock rising edges.
// - Read starts with read select low at true input rise; address captured then.
// - First read word driven from the inverse output clock rise of cycle t+1.
// - Second read word, from address plus one, driven on true output rise t+2.
// - Read data appears one and a half cycles after address capture, A+0 then A+1.
// - Read bus released after the next output clock rise once a burst ends.
// - Write starts with write select low at true input rise; first word captured.
// - Inverse input rise captures write address and second word; 36 bits written.
// - First and second write words land at A+0 and A+1.
// - Deselected write port completes a pending write then ignores inputs.
// - Byte selects sampled with each word; active writes, inactive keeps stored byte.
// - Single-clock mode clocks outputs from input clocks as if zero skew.
// - Single-clock mode: both output clocks high at power-on, fixed strap.
// - Read and write ports run independently and may start in one cycle.
// - Same-address read returns the most recent data, including a just-started write.
// - Port selects sampled only on true input rise; one port never affects other.
// - Both selects high: nothing starts, write data ignored, read bus released.
// - Pending reads and writes complete before a deselect takes effect.
// - Output impedance updated once every 1024 input clock cycles.
// - Free-running echo clocks follow output clocks, or input clocks in single mode.
// - DLL resets when input clock period exceeds 30 ns; disable pin low turns it off.
// - Power-up with both ports deselected and read bus released.
// - Byte select 0 guards bits 8:0, select 1 bits 17:9; high means no write.
`timescale 1ns/1ps
`default_nettype none

module burst2_sram_ports (
  input  wire logic                                  MCLK_IN,
  input  wire logic                                  RESETN_IN,
  input  wire logic                                  INPUT_TIMING_TRUE_IN,
  input  wire logic                                  INPUT_TIMING_INVERSE_IN,
  input  wire logic                                  OUTPUT_TIMING_TRUE_IN,
  input  wire logic                                  OUTPUT_TIMING_INVERSE_IN,
  input  wire logic [burst2_sram_pkg::ADDR_W-1:0]    ADDRESS_IN,
  input  wire logic [burst2_sram_pkg::WORD_W-1:0]    WRITE_INPUT_BUS_IN,
  input  wire logic [burst2_sram_pkg::BWS_W-1:0]     BYTE_WRITE_SELECT_N_IN,
  input  wire logic                                  READ_PORT_SELECT_N_IN,
  input  wire logic                                  WRITE_PORT_SELECT_N_IN,
  input  wire logic                                  LOOP_DISABLE_PIN_N_IN,
  output logic      [burst2_sram_pkg::WORD_W-1:0]    READ_OUTPUT_BUS_OUT,
  output logic                                       READ_OUTPUT_BUS_OE_OUT,
  output logic                                       ECHO_TIMING_OUT,
  output logic                                       ECHO_TIMING_N_OUT,
  output logic                                       IMPEDANCE_UPDATE_OUT,
  output logic                                       DLL_ACTIVE_OUT,
  output logic                                       SINGLE_CLOCK_MODE_OUT
);

  // Merge a new word into a stored one under active-low lane selects
  function automatic logic [burst2_sram_pkg::WORD_W-1:0] lane_merge(
    input logic [burst2_sram_pkg::WORD_W-1:0] old_word,
    input logic [burst2_sram_pkg::WORD_W-1:0] new_word,
    input logic [burst2_sram_pkg::BWS_W-1:0]  sel_n
  );
    logic [burst2_sram_pkg::WORD_W-1:0] w;
    w = old_word;
    if (!sel_n[0]) begin
      w[burst2_sram_pkg::LANE0_MSB:burst2_sram_pkg::LANE0_LSB] =
        new_word[burst2_sram_pkg::LANE0_MSB:burst2_sram_pkg::LANE0_LSB];
    end
    if (!sel_n[1]) begin
      w[burst2_sram_pkg::LANE1_MSB:burst2_sram_pkg::LANE1_LSB] =
        new_word[burst2_sram_pkg::LANE1_MSB:burst2_sram_pkg::LANE1_LSB];
    end
    return w;
  endfunction

  // Two-flop synchronisers for every pin
  burst2_sram_pkg::req_pins_s req_meta_q, req_q;
  burst2_sram_pkg::clk_pins_s clk_meta_q, clk_q, clk_prev_q;
  logic                       dis_meta_q, dis_n_q;

  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      req_meta_q <= burst2_sram_pkg::REQ_IDLE;
      req_q      <= burst2_sram_pkg::REQ_IDLE;
      clk_meta_q <= burst2_sram_pkg::CLK_IDLE;
      clk_q      <= burst2_sram_pkg::CLK_IDLE;
      clk_prev_q <= burst2_sram_pkg::CLK_IDLE;
      dis_meta_q <= 1'b0;
      dis_n_q    <= 1'b0;
    end else begin
      req_meta_q <= '{addr: ADDRESS_IN, data: WRITE_INPUT_BUS_IN,
                      bws_n: BYTE_WRITE_SELECT_N_IN, rps_n: READ_PORT_SELECT_N_IN,
                      wps_n: WRITE_PORT_SELECT_N_IN};
      req_q      <= req_meta_q;
      clk_meta_q <= '{k: INPUT_TIMING_TRUE_IN, k_n: INPUT_TIMING_INVERSE_IN,
                      c: OUTPUT_TIMING_TRUE_IN, c_n: OUTPUT_TIMING_INVERSE_IN};
      clk_q      <= clk_meta_q;
      clk_prev_q <= clk_q;
      dis_meta_q <= LOOP_DISABLE_PIN_N_IN;
      dis_n_q    <= dis_meta_q;
    end
  end

  // State
  logic [burst2_sram_pkg::STRAP_CNT_W-1:0] strap_cnt_q, strap_cnt_d;
  logic                                    strap_done_q, strap_done_d;
  logic                                    single_q, single_d;
  logic [burst2_sram_pkg::ADDR_W-1:0]      rd_addr_q, rd_addr_d;
  logic                                    rd_pend_q, rd_pend_d;
  logic [burst2_sram_pkg::PAIR_W-1:0]      pair_q, pair_d;
  logic                                    pair_vld_q, pair_vld_d;
  logic [burst2_sram_pkg::WORD_W-1:0]      word1_q, word1_d;
  logic [burst2_sram_pkg::WORD_W-1:0]      q_q, q_d;
  logic                                    oe_q, oe_d;
  burst2_sram_pkg::out_phase_e             phase_q, phase_d;
  logic [burst2_sram_pkg::WORD_W-1:0]      wd0_q, wd0_d;
  logic [burst2_sram_pkg::BWS_W-1:0]       wbws0_q, wbws0_d;
  logic                                    wr_pend_q, wr_pend_d;
  logic                                    echo_q, echo_d, echo_n_q, echo_n_d;
  logic [burst2_sram_pkg::IMP_CNT_W-1:0]   imp_cnt_q, imp_cnt_d;
  logic                                    imp_upd_q, imp_upd_d;
  logic [burst2_sram_pkg::DLL_CNT_W-1:0]   per_cnt_q, per_cnt_d;
  logic                                    dll_rst_q, dll_rst_d;

  // Array storage, one array per burst word
  logic [burst2_sram_pkg::WORD_W-1:0] mem0 [burst2_sram_pkg::ARRAY_DEPTH];
  logic [burst2_sram_pkg::WORD_W-1:0] mem1 [burst2_sram_pkg::ARRAY_DEPTH];

  logic                               k_rise, kn_rise, c_rise, cn_rise;
  logic                               out_true_rise, out_inv_rise;
  logic                               wr_commit;
  logic [burst2_sram_pkg::WORD_W-1:0] wr_word0, wr_word1, rd_word0, rd_word1;

  always_comb begin
    k_rise        = strap_done_q && clk_q.k && !clk_prev_q.k;
    kn_rise       = strap_done_q && clk_q.k_n && !clk_prev_q.k_n;
    c_rise        = strap_done_q && clk_q.c && !clk_prev_q.c;
    cn_rise       = strap_done_q && clk_q.c_n && !clk_prev_q.c_n;
    out_true_rise = single_q ? k_rise : c_rise;
    out_inv_rise  = single_q ? kn_rise : cn_rise;
    // Second word and address on the inverse input edge; lanes per word
    wr_commit = kn_rise && wr_pend_q;
    wr_word0  = lane_merge(mem0[req_q.addr], wd0_q, wbws0_q);
    wr_word1  = lane_merge(mem1[req_q.addr], req_q.data, req_q.bws_n);
    // Forward a write landing on the same edge as the array read
    if (wr_commit && req_q.addr == rd_addr_q) begin
      rd_word0 = wr_word0;
      rd_word1 = wr_word1;
    end else begin
      rd_word0 = mem0[rd_addr_q];
      rd_word1 = mem1[rd_addr_q];
    end
  end

  // Array write: A+0 word to the first array, A+1 word to the second
  always_ff @(posedge MCLK_IN) begin
    if (wr_commit) begin
      mem0[req_q.addr] <= wr_word0;
      mem1[req_q.addr] <= wr_word1;
    end
  end

  always_comb begin
    strap_cnt_d  = strap_cnt_q;
    strap_done_d = strap_done_q;
    single_d     = single_q;
    rd_addr_d    = rd_addr_q;
    rd_pend_d    = rd_pend_q;
    pair_d       = pair_q;
    pair_vld_d   = pair_vld_q;
    word1_d      = word1_q;
    q_d          = q_q;
    oe_d         = oe_q;
    phase_d      = phase_q;
    wd0_d        = wd0_q;
    wbws0_d      = wbws0_q;
    wr_pend_d    = wr_pend_q;
    imp_cnt_d    = imp_cnt_q;
    imp_upd_d    = 1'b0;
    per_cnt_d    = per_cnt_q;
    dll_rst_d    = dll_rst_q;

    // Strap caught once after reset release, when synchronisers have settled
    if (!strap_done_q) begin
      if (strap_cnt_q == burst2_sram_pkg::STRAP_CNT_W'(burst2_sram_pkg::STRAP_SETTLE_CYCLES)) begin
        strap_done_d = 1'b1;
        single_d     = clk_q.c && clk_q.c_n;
      end else begin
        strap_cnt_d = strap_cnt_q + 1'b1;
      end
    end

    // Selects sampled on the true input rise only
    if (k_rise) begin
      // Previous read moves to the output stage while a new one is captured
      pair_d     = {rd_word1, rd_word0};
      pair_vld_d = rd_pend_q;
      rd_pend_d  = !req_q.rps_n;
      rd_addr_d  = req_q.addr;
      wr_pend_d  = !req_q.wps_n;
      wd0_d      = req_q.data;
      wbws0_d    = req_q.bws_n;
      imp_cnt_d  = imp_cnt_q + 1'b1;
      if (imp_cnt_q == burst2_sram_pkg::IMP_CNT_W'(burst2_sram_pkg::IMP_UPDATE_CYCLES - 1)) begin
        imp_upd_d = 1'b1;
      end
    end else if (wr_commit) begin
      wr_pend_d = 1'b0;
    end

    // Output stage
    if (out_inv_rise) begin
      if (pair_vld_q) begin
        q_d        = pair_q[burst2_sram_pkg::WORD_W-1:0];
        word1_d    = pair_q[burst2_sram_pkg::PAIR_W-1:burst2_sram_pkg::WORD_W];
        oe_d       = 1'b1;
        phase_d    = burst2_sram_pkg::OUT_FIRST;
        pair_vld_d = k_rise ? rd_pend_q : 1'b0;
      end else begin
        oe_d    = 1'b0;
        phase_d = burst2_sram_pkg::OUT_IDLE;
      end
    end else if (out_true_rise) begin
      case (phase_q)
        burst2_sram_pkg::OUT_FIRST: begin
          q_d     = word1_q;
          phase_d = burst2_sram_pkg::OUT_SECOND;
        end
        burst2_sram_pkg::OUT_SECOND: begin
          phase_d = burst2_sram_pkg::OUT_SECOND;
        end
        default: begin
          phase_d = burst2_sram_pkg::OUT_IDLE;
        end
      endcase
    end

    // Input clock period watch for DLL reset
    if (k_rise) begin
      per_cnt_d = '0;
      dll_rst_d = per_cnt_q > burst2_sram_pkg::DLL_CNT_W'(burst2_sram_pkg::DLL_RESET_CYCLES);
    end else if (per_cnt_q != '1) begin
      per_cnt_d = per_cnt_q + 1'b1;
    end
    if (per_cnt_q > burst2_sram_pkg::DLL_CNT_W'(burst2_sram_pkg::DLL_RESET_CYCLES)) begin
      dll_rst_d = 1'b1;
    end

    // Echo clocks track the output clocks, or input clocks in single mode
    echo_d   = single_q ? clk_q.k : clk_q.c;
    echo_n_d = single_q ? clk_q.k_n : clk_q.c_n;
  end

  // Only the strap logic, period counter, DLL reset and the end of the impedance pulse move without clock pin edges; stopped clocks hold the rest
  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      strap_cnt_q  <= '0;
      strap_done_q <= 1'b0;
      single_q     <= 1'b0;
      rd_addr_q    <= burst2_sram_pkg::ADDR_RESET;
      rd_pend_q    <= 1'b0;
      pair_q       <= burst2_sram_pkg::PAIR_RESET;
      pair_vld_q   <= 1'b0;
      word1_q      <= burst2_sram_pkg::WORD_RESET;
      q_q          <= burst2_sram_pkg::WORD_RESET;
      oe_q         <= 1'b0;
      phase_q      <= burst2_sram_pkg::OUT_IDLE;
      wd0_q        <= burst2_sram_pkg::WORD_RESET;
      wbws0_q      <= burst2_sram_pkg::BWS_RESET;
      wr_pend_q    <= 1'b0;
      echo_q       <= 1'b0;
      echo_n_q     <= 1'b0;
      imp_cnt_q    <= '0;
      imp_upd_q    <= 1'b0;
      per_cnt_q    <= '1;
      dll_rst_q    <= 1'b1;
    end else begin
      strap_cnt_q  <= strap_cnt_d;
      strap_done_q <= strap_done_d;
      single_q     <= single_d;
      rd_addr_q    <= rd_addr_d;
      rd_pend_q    <= rd_pend_d;
      pair_q       <= pair_d;
      pair_vld_q   <= pair_vld_d;
      word1_q      <= word1_d;
      q_q          <= q_d;
      oe_q         <= oe_d;
      phase_q      <= phase_d;
      wd0_q        <= wd0_d;
      wbws0_q      <= wbws0_d;
      wr_pend_q    <= wr_pend_d;
      echo_q       <= echo_d;
      echo_n_q     <= echo_n_d;
      imp_cnt_q    <= imp_cnt_d;
      imp_upd_q    <= imp_upd_d;
      per_cnt_q    <= per_cnt_d;
      dll_rst_q    <= dll_rst_d;
    end
  end

  assign READ_OUTPUT_BUS_OUT    = q_q;
  assign READ_OUTPUT_BUS_OE_OUT = oe_q;
  assign ECHO_TIMING_OUT        = echo_q;
  assign ECHO_TIMING_N_OUT      = echo_n_q;
  assign IMPEDANCE_UPDATE_OUT   = imp_upd_q;
  assign DLL_ACTIVE_OUT         = dis_n_q && !dll_rst_q;
  assign SINGLE_CLOCK_MODE_OUT  = single_q;

endmodule

`default_nettype wire

// file: burst2_sram_pkg.sv
// Constants and pin bundles shared by the burst-of-two SRAM port logic
package burst2_sram_pkg;

  // Array organisation: two arrays, one per burst word
  localparam int ADDR_W      = 19;
  localparam int WORD_W      = 18;
  localparam int PAIR_W      = 2 * WORD_W;
  localparam int ARRAY_DEPTH = 524288;
  localparam int BWS_W       = 2;

  // Byte lanes inside one 18-bit word
  localparam int LANE0_LSB = 0;
  localparam int LANE0_MSB = 8;
  localparam int LANE1_LSB = 9;
  localparam int LANE1_MSB = 17;

  // Timing, in ns and in system clock cycles; impedance update interval in input clock cycles
  localparam int CLK_PERIOD_NS        = 5;
  localparam int DLL_RESET_PERIOD_NS  = 30;
  localparam int DLL_RESET_CYCLES     = DLL_RESET_PERIOD_NS / CLK_PERIOD_NS;
  localparam int DLL_CNT_W            = 4;
  localparam int IMP_UPDATE_CYCLES    = 1024;
  localparam int IMP_CNT_W            = 10;
  localparam int STRAP_SETTLE_CYCLES  = 3;
  localparam int STRAP_CNT_W          = 2;

  // Reset values
  localparam logic [WORD_W-1:0] WORD_RESET = 18'h00000;
  localparam logic [PAIR_W-1:0] PAIR_RESET = 36'h000000000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 19'h00000;
  localparam logic [BWS_W-1:0]  BWS_RESET  = 2'h3;

  // Sampled request pins
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] data;
    logic [BWS_W-1:0]  bws_n;
    logic              rps_n;
    logic              wps_n;
  } req_pins_s;

  // Sampled clock pins
  typedef struct packed {
    logic k;
    logic k_n;
    logic c;
    logic c_n;
  } clk_pins_s;

  localparam req_pins_s REQ_IDLE = '{addr: 19'h00000, data: 18'h00000, bws_n: 2'h3,
                                     rps_n: 1'b1, wps_n: 1'b1};
  localparam clk_pins_s CLK_IDLE = '{k: 1'b0, k_n: 1'b0, c: 1'b0, c_n: 1'b0};

  // Read output phase, Gray coded along idle -> first -> second
  typedef enum logic [1:0] {
    OUT_IDLE   = 2'b00,
    OUT_FIRST  = 2'b01,
    OUT_SECOND = 2'b11
  } out_phase_e;

endpackage

// file: burst2_sram_monitor.sv
// Checker for the burst-of-two SRAM port pins
`timescale 1ns/1ps
`default_nettype none

module burst2_sram_monitor (
  input wire logic        MCLK_IN,
  input wire logic        RESETN_IN,
  input wire logic        INPUT_TIMING_TRUE_IN,
  input wire logic        INPUT_TIMING_INVERSE_IN,
  input wire logic        OUTPUT_TIMING_TRUE_IN,
  input wire logic        OUTPUT_TIMING_INVERSE_IN,
  input wire logic        LOOP_DISABLE_PIN_N_IN,
  input wire logic [17:0] READ_OUTPUT_BUS_OUT,
  input wire logic        READ_OUTPUT_BUS_OE_OUT,
  input wire logic        ECHO_TIMING_OUT,
  input wire logic        ECHO_TIMING_N_OUT,
  input wire logic        IMPEDANCE_UPDATE_OUT,
  input wire logic        DLL_ACTIVE_OUT,
  input wire logic        SINGLE_CLOCK_MODE_OUT
);
  logic [3:0] pins;
  logic [3:0] clk_q, clk_d, k_age_q, k_age_d, clk_age_q, clk_age_d, rst_age_q, rst_age_d;

  assign pins = {INPUT_TIMING_TRUE_IN, INPUT_TIMING_INVERSE_IN, OUTPUT_TIMING_TRUE_IN,
                 OUTPUT_TIMING_INVERSE_IN};

  // Saturating ages: since true input rise, since any clock pin change, since reset
  always_comb begin
    clk_d     = pins;
    k_age_d   = (pins[3] && !clk_q[3]) ? 4'h0 : k_age_q + {3'h0, k_age_q != 4'hF};
    clk_age_d = (pins != clk_q) ? 4'h0 : clk_age_q + {3'h0, clk_age_q != 4'hF};
    rst_age_d = rst_age_q + {3'h0, rst_age_q != 4'hF};
  end

  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      clk_q     <= 4'h0;
      k_age_q   <= 4'hF;
      clk_age_q <= 4'h0;
      rst_age_q <= 4'h0;
    end else begin
      clk_q     <= clk_d;
      k_age_q   <= k_age_d;
      clk_age_q <= clk_age_d;
      rst_age_q <= rst_age_d;
    end
  end

  default clocking mon_cb @(posedge MCLK_IN);
  endclocking
  default disable iff (!RESETN_IN);

  echo_true_a: assert property (
    rst_age_q > 4'h7 && !SINGLE_CLOCK_MODE_OUT && $rose(OUTPUT_TIMING_TRUE_IN)
    |-> ##[1:5] $rose(ECHO_TIMING_OUT)) else $error("echo did not follow output clock");
  echo_inverse_a: assert property (
    rst_age_q > 4'h7 && !SINGLE_CLOCK_MODE_OUT && $rose(OUTPUT_TIMING_INVERSE_IN)
    |-> ##[1:5] $rose(ECHO_TIMING_N_OUT)) else $error("inverse echo did not follow");
  echo_single_a: assert property (
    rst_age_q > 4'h7 && SINGLE_CLOCK_MODE_OUT && $rose(INPUT_TIMING_TRUE_IN)
    |-> ##[1:5] $rose(ECHO_TIMING_OUT)) else $error("echo did not follow input clock");
  dll_off_a: assert property (
    !LOOP_DISABLE_PIN_N_IN [*5] |-> !DLL_ACTIVE_OUT) else $error("loop active while disabled");
  dll_slow_a: assert property (
    k_age_q > 4'h9 |-> !DLL_ACTIVE_OUT) else $error("loop active with slow input clock");
  imp_pulse_a: assert property (
    IMPEDANCE_UPDATE_OUT |=> !IMPEDANCE_UPDATE_OUT [*8]) else $error("impedance pulse too long");
  bus_hold_a: assert property (
    $changed(READ_OUTPUT_BUS_OUT) || $changed(READ_OUTPUT_BUS_OE_OUT) |-> clk_age_q < 4'h7)
    else $error("read bus moved without a clock edge");
  strap_fixed_a: assert property (
    rst_age_q > 4'h7 |-> $stable(SINGLE_CLOCK_MODE_OUT)) else $error("strap changed in operation");
endmodule

`default_nettype wire

// file: ctrl_clock_model.sv
// Controller-side clock pairs for the burst-of-two SRAM
`timescale 1ns/1ps
`default_nettype none

module ctrl_clock_model (
  input  wire logic run_in,
  input  wire logic fast_in,
  input  wire logic single_in,
  output logic      k_out,
  output logic      k_n_out,
  output logic      c_out,
  output logic      c_n_out
);
  logic k_q = 1'b0;

  // Clocks freeze between frames while run is low
  always begin
    #(fast_in ? 12.5 : 32.0);
    if (run_in) k_q = ~k_q;
  end

  assign k_out   = k_q;
  assign k_n_out = ~k_q;
  // Output pair held high selects single-clock mode, else zero skew to inputs
  assign c_out   = single_in | k_q;
  assign c_n_out = single_in | ~k_q;
endmodule

`default_nettype wire

// file: burst2_sram_ports_tb_top.sv
// Self-checking bench for the burst-of-two SRAM ports
`timescale 1ns/1ps
`default_nettype none

module burst2_sram_ports_tb_top;
  logic        mclk = 1'b0, rst_n = 1'b0, run = 1'b0, fast = 1'b0, single = 1'b0;
  logic        loop_n = 1'b1, rps_n = 1'b1, wps_n = 1'b1, rd_p = 1'b0;
  logic        k, k_n, c, c_n, oe, echo, echo_n, imp, dll, single_mode;
  logic [18:0] addr = 19'h00000, rd_a = 19'h00000;
  logic [17:0] wdata = 18'h00000, rbus;
  logic [1:0]  bws_n = 2'h3;
  logic [31:0] lfsr_q = 32'h27;
  logic [35:0] mem_r [logic [18:0]];
  logic [18:0] a_r [8];
  logic [17:0] exp_q [$];
  int          fail_count = 0, n_tests = 0, k_cnt = 0, n0;

  always #2.5 mclk = ~mclk;
  always @(posedge k) k_cnt++;

  ctrl_clock_model host (.run_in(run), .fast_in(fast), .single_in(single), .k_out(k),
    .k_n_out(k_n), .c_out(c), .c_n_out(c_n));

  burst2_sram_ports dut (.MCLK_IN(mclk), .RESETN_IN(rst_n), .INPUT_TIMING_TRUE_IN(k),
    .INPUT_TIMING_INVERSE_IN(k_n), .OUTPUT_TIMING_TRUE_IN(c), .OUTPUT_TIMING_INVERSE_IN(c_n),
    .ADDRESS_IN(addr), .WRITE_INPUT_BUS_IN(wdata), .BYTE_WRITE_SELECT_N_IN(bws_n),
    .READ_PORT_SELECT_N_IN(rps_n), .WRITE_PORT_SELECT_N_IN(wps_n),
    .LOOP_DISABLE_PIN_N_IN(loop_n), .READ_OUTPUT_BUS_OUT(rbus), .READ_OUTPUT_BUS_OE_OUT(oe),
    .ECHO_TIMING_OUT(echo), .ECHO_TIMING_N_OUT(echo_n), .IMPEDANCE_UPDATE_OUT(imp),
    .DLL_ACTIVE_OUT(dll), .SINGLE_CLOCK_MODE_OUT(single_mode));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Lane merge: a high select keeps the stored lane
  function automatic logic [17:0] mrg(input logic [17:0] o, input logic [17:0] n,
                                      input logic [1:0] s);
    return {s[1] ? o[17:9] : n[17:9], s[0] ? o[8:0] : n[8:0]};
  endfunction

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    if (fail_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // One input clock cycle: selects and word0 for the true rise, address and word1 after
  task automatic op(input logic rd, input logic wr, input logic [18:0] ra,
                    input logic [18:0] wa, input logic [1:0] b0, input logic [1:0] b1);
    logic [17:0] d0, d1;
    lfsr_q = lfsr(lfsr_q);
    d0 = lfsr_q[17:0];
    d1 = lfsr_q[31:14];
    @(posedge k_n);
    tick(3);
    rps_n = !rd;
    wps_n = !wr;
    addr = ra;
    wdata = d0;
    bws_n = b0;
    // The previous read fetches at this true rise, before this cycle's write lands
    if (rd_p) begin
      exp_q.push_back(mem_r[rd_a][17:0]);
      exp_q.push_back(mem_r[rd_a][35:18]);
    end
    if (wr) mem_r[wa] = {mrg(mem_r[wa][35:18], d1, b1), mrg(mem_r[wa][17:0], d0, b0)};
    rd_p = rd;
    rd_a = ra;
    @(posedge k);
    tick(3);
    addr = wa;
    wdata = d1;
    bws_n = b1;
  endtask

  initial begin
    logic [17:0] e;
    forever begin
      @(posedge k or posedge k_n);
      repeat (5) @(posedge mclk);
      if (oe === 1'b1) begin
        e = (exp_q.size() > 0) ? exp_q.pop_front() : ~rbus;
        chk({18'h00000, rbus}, {18'h00000, e});
      end
    end
  end

  initial begin
    #250000;
    fail_count++;
    test_done();
  end

  initial begin
    tick(3);
    rst_n = 1'b1;
    tick(10);
    chk({35'h0, single_mode}, 36'h0);
    run = 1'b1;
    op(1'b0, 1'b0, 19'h00000, 19'h00000, 2'h3, 2'h3);
    for (int i = 0; i < 8; i++) begin
      a_r[i] = lfsr_q[18:0];
      op(i > 0, 1'b1, a_r[(i > 0) ? i - 1 : 0], a_r[i], 2'h0, 2'h0);
    end
    for (int i = 0; i < 8; i++) begin
      op(1'b1, 1'b0, a_r[i], a_r[i], 2'h0, 2'h0);
    end
    for (int j = 0; j < 4; j++) begin
      op(1'b1, 1'b1, a_r[0], a_r[0], j[1:0], ~j[1:0]);
    end
    op(1'b1, 1'b0, a_r[1], a_r[1], 2'h0, 2'h0);
    op(1'b0, 1'b1, a_r[1], a_r[1], 2'h0, 2'h0);
    op(1'b0, 1'b0, a_r[2], a_r[2], 2'h0, 2'h0);
    op(1'b1, 1'b0, a_r[2], a_r[2], 2'h0, 2'h0);
    op(1'b0, 1'b0, a_r[2], a_r[2], 2'h3, 2'h3);
    // Let the last burst drain and be checked before the clocks speed up
    tick(40);
    fast = 1'b1;
    repeat (10) @(posedge k);
    tick(1);
    chk({35'h0, dll}, 36'h1);
    loop_n = 1'b0;
    tick(8);
    chk({35'h0, dll}, 36'h0);
    loop_n = 1'b1;
    fast = 1'b0;
    repeat (3) @(posedge k);
    tick(1);
    chk({35'h0, dll}, 36'h0);
    @(posedge imp);
    n0 = k_cnt;
    @(posedge imp);
    chk(36'(k_cnt - n0), 36'(burst2_sram_pkg::IMP_UPDATE_CYCLES));
    tick(1);
    run = 1'b0;
    single = 1'b1;
    rst_n = 1'b0;
    tick(3);
    rst_n = 1'b1;
    tick(10);
    chk({35'h0, single_mode}, 36'h1);
    run = 1'b1;
    op(1'b1, 1'b1, a_r[3], a_r[3], 2'h0, 2'h0);
    op(1'b1, 1'b0, a_r[4], a_r[4], 2'h0, 2'h0);
    op(1'b0, 1'b0, a_r[4], a_r[4], 2'h3, 2'h3);
    op(1'b0, 1'b0, a_r[4], a_r[4], 2'h3, 2'h3);
    tick(40);
    chk(36'(exp_q.size()), 36'h0);
    test_done();
  end
endmodule

bind burst2_sram_ports burst2_sram_monitor u_mon (.MCLK_IN(MCLK_IN), .RESETN_IN(RESETN_IN),
  .INPUT_TIMING_TRUE_IN(INPUT_TIMING_TRUE_IN), .INPUT_TIMING_INVERSE_IN(INPUT_TIMING_INVERSE_IN),
  .OUTPUT_TIMING_TRUE_IN(OUTPUT_TIMING_TRUE_IN),
  .OUTPUT_TIMING_INVERSE_IN(OUTPUT_TIMING_INVERSE_IN),
  .LOOP_DISABLE_PIN_N_IN(LOOP_DISABLE_PIN_N_IN), .READ_OUTPUT_BUS_OUT(READ_OUTPUT_BUS_OUT),
  .READ_OUTPUT_BUS_OE_OUT(READ_OUTPUT_BUS_OE_OUT), .ECHO_TIMING_OUT(ECHO_TIMING_OUT),
  .ECHO_TIMING_N_OUT(ECHO_TIMING_N_OUT), .IMPEDANCE_UPDATE_OUT(IMPEDANCE_UPDATE_OUT),
  .DLL_ACTIVE_OUT(DLL_ACTIVE_OUT), .SINGLE_CLOCK_MODE_OUT(SINGLE_CLOCK_MODE_OUT));

`default_nettype wire
